//--- rtl/io_timer_consts.vh
`ifndef IO_TIMER_CONSTS_VH
`define IO_TIMER_CONSTS_VH

// ==========================================
// Register map (byte addresses)
`define IOT_ADDR_W 12
`define IOT_OFS_CTRL 12'h000
`define IOT_OFS_STAT 12'h004

// ==========================================
// Timer control field positions
`define IOT_TCHOICE_HI 27
`define IOT_TCHOICE_LO 24
`define IOT_TPOL_BIT 23
`define IOT_TRGORG_BIT 22
`define IOT_PDRIVE_HI 17
`define IOT_PDRIVE_LO 16
`define IOT_PCHOICE_HI 10
`define IOT_PCHOICE_LO 8
`define IOT_PPOL_BIT 7

// Writable bits; reserved bits read back as zero
`define IOT_CTRL_WMASK 32'h0FC30780
`define IOT_CTRL_RESET 32'h00000000

// ==========================================
// Status register bit positions
`define IOT_ST_TRIG_BIT 0
`define IOT_ST_PIN_BIT 1
`define IOT_ST_RAW_BIT 2

// ==========================================
// Pin drive configurations
`define IOT_PCFG_OFF 2'h0
`define IOT_PCFG_OD_OE 2'h1
`define IOT_PCFG_BIDIR 2'h2
`define IOT_PCFG_OUT 2'h3

// Internal trigger choice decode
`define IOT_SEL_PIN_TAG 1'b0
`define IOT_SEL_SHF_TAG 2'h1
`define IOT_SEL_TMR_TAG 2'h3

// Width of the padded source vectors
`define IOT_VEC_W 16
`define IOT_IDX_W 4

`endif

//--- rtl/io_sync3.v
`timescale 1ns/10ps

// ==========================================
// Three-stage synchroniser with agreement filter
module io_sync3 #(
   parameter W = 8
) (
   input wire pclk,
   input wire presetn,
   input wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

reg [W-1:0] meta_ff;
reg [W-1:0] s2_ff;
reg [W-1:0] s3_ff;
reg [W-1:0] stable_ff;
wire [W-1:0] nxt_stable;

// A bit only moves once stages two and three agree, so a
// sample caught mid-transition never leaks through
assign nxt_stable = (s2_ff & s3_ff) | (stable_ff & (s2_ff | s3_ff));

// Chain; the first stage feeds only the second
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      meta_ff <= {W{1'b0}};
      s2_ff <= {W{1'b0}};
      s3_ff <= {W{1'b0}};
      stable_ff <= {W{1'b0}};
   end
   else
   begin
      meta_ff <= async_in;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
      stable_ff <= nxt_stable;
   end
end

assign sync_out = stable_ff;

endmodule

//--- rtl/io_timer_trigger_pin_config.v
// Functional notes
// - Internal choice: 2N pin, 4N+1 shifter, 4N+3 timer
// - Origin bit 22: 0 external, 1 internal
// - Polarity bit 23: 1 inverts the trigger
// - Bits 17:16 set the timer pin drive
// - Bits 10:8 pick the timer pin
// - Bits 21:18 and 15:11 read zero
// - Bit 7: 1 makes the pin active low
`timescale 1ns/10ps
`include "io_timer_consts.vh"

module io_timer_trigger_pin_config #(
   parameter NPINS = 8,
   parameter NSHIFT = 4,
   parameter NTIMERS = 4,
   parameter NEXT = 4
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`IOT_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire [NPINS-1:0] pin_in,
   input wire [NEXT-1:0] ext_trig,
   input wire [NSHIFT-1:0] shifter_flag,
   input wire [NTIMERS-1:0] timer_trig,
   input wire timer_out,
   output wire [NPINS-1:0] pin_out,
   output wire [NPINS-1:0] pin_oe,
   output wire trigger_active,
   output wire timer_pin_in
);

// ==========================================
// Declarations
reg [31:0] ctrl_ff;
reg [31:0] prdata_ff;
reg pready_ff;
reg pslverr_ff;
reg [NPINS-1:0] pin_out_ff;
reg [NPINS-1:0] pin_oe_ff;
reg trig_ff;
reg pin_in_ff;
reg [31:0] nxt_prdata;
reg nxt_slverr;
reg [NPINS-1:0] nxt_pin_out;
reg [NPINS-1:0] nxt_pin_oe;
reg nxt_int_trig;

wire [NPINS-1:0] pin_sync;
wire [NEXT-1:0] ext_sync;
wire [`IOT_VEC_W-1:0] pin_vec;
wire [`IOT_VEC_W-1:0] ext_vec;
wire [`IOT_VEC_W-1:0] shf_vec;
wire [`IOT_VEC_W-1:0] tmr_vec;
wire [`IOT_IDX_W-1:0] trigger_choice;
wire trigger_polarity;
wire trigger_origin;
wire [1:0] pin_drive_config;
wire [2:0] pin_choice;
wire pin_polarity;
wire apb_setup;
wire apb_done;
wire hit_ctrl;
wire hit_stat;
wire nxt_raw_trig;
wire nxt_trig;
wire nxt_pin_in;
wire drive_level;
wire [31:0] stat_word;

// ==========================================
// Helpers

// Picks one bit of a padded source vector; indices past the
// real source count read as zero
function pick_bit;
   input [`IOT_VEC_W-1:0] vec;
   input [`IOT_IDX_W-1:0] idx;
   begin
      pick_bit = vec[idx];
   end
endfunction

// Exact match of a register offset on the word address
function addr_is;
   input [`IOT_ADDR_W-1:0] addr;
   input [`IOT_ADDR_W-1:0] ofs;
   begin
      addr_is = (addr[`IOT_ADDR_W-1:2] == ofs[`IOT_ADDR_W-1:2]);
   end
endfunction

// ==========================================
// Input synchronisers

// Pins and external triggers come from outside this clock
io_sync3 #(
   .W(NPINS)
) u_pin_sync (
   .pclk(pclk),
   .presetn(presetn),
   .async_in(pin_in),
   .sync_out(pin_sync)
);

io_sync3 #(
   .W(NEXT)
) u_ext_sync (
   .pclk(pclk),
   .presetn(presetn),
   .async_in(ext_trig),
   .sync_out(ext_sync)
);

// Zero-pad every source to the mux width; counts must stay
// below the padded width of sixteen
assign pin_vec = {{(`IOT_VEC_W-NPINS){1'b0}}, pin_sync};
assign ext_vec = {{(`IOT_VEC_W-NEXT){1'b0}}, ext_sync};
assign shf_vec = {{(`IOT_VEC_W-NSHIFT){1'b0}}, shifter_flag};
assign tmr_vec = {{(`IOT_VEC_W-NTIMERS){1'b0}}, timer_trig};

// ==========================================
// Control fields
assign trigger_choice = ctrl_ff[`IOT_TCHOICE_HI:`IOT_TCHOICE_LO];
assign trigger_polarity = ctrl_ff[`IOT_TPOL_BIT];
assign trigger_origin = ctrl_ff[`IOT_TRGORG_BIT];
assign pin_drive_config = ctrl_ff[`IOT_PDRIVE_HI:`IOT_PDRIVE_LO];
assign pin_choice = ctrl_ff[`IOT_PCHOICE_HI:`IOT_PCHOICE_LO];
assign pin_polarity = ctrl_ff[`IOT_PPOL_BIT];

// ==========================================
// APB decode

// One wait state: the access phase ends on its second cycle,
// which gives the read mux a full cycle of slack
assign apb_setup = psel & penable & ~pready_ff;
assign apb_done = psel & penable & pready_ff;
assign hit_ctrl = addr_is(paddr, `IOT_OFS_CTRL);
assign hit_stat = addr_is(paddr, `IOT_OFS_STAT);

// Status word shows the live trigger and pin state
assign stat_word = ({31'h0, trig_ff} << `IOT_ST_TRIG_BIT)
   | ({31'h0, pin_in_ff} << `IOT_ST_PIN_BIT)
   | ({31'h0, nxt_raw_trig} << `IOT_ST_RAW_BIT);

// Read data and error answer, prepared in the wait cycle
always @*
begin
   nxt_prdata = prdata_ff;
   nxt_slverr = pslverr_ff;
   if (apb_setup)
   begin
      nxt_prdata = 32'h00000000;
      nxt_slverr = 1'b0;
      if (hit_ctrl)
      begin
         if (!pwrite)
         begin
            nxt_prdata = ctrl_ff & `IOT_CTRL_WMASK;
         end
      end
      else if (hit_stat)
      begin
         if (!pwrite)
         begin
            nxt_prdata = stat_word;
         end
      end
      else
      begin
         nxt_slverr = 1'b1;
      end
   end
   else if (apb_done)
   begin
      nxt_slverr = 1'b0;
   end
end

// Bus handshake and control register
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      ctrl_ff <= `IOT_CTRL_RESET;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
   end
   else
   begin
      pready_ff <= apb_setup;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_slverr;
      // Write lands only on the completing edge; reserved bits
      // never store, so they cannot read back as one
      if (apb_done && pwrite && hit_ctrl)
      begin
         ctrl_ff <= pwdata & `IOT_CTRL_WMASK;
      end
   end
end

// ==========================================
// Trigger selection

// Internal source by the low bits of the choice; values that
// name a missing source simply yield an idle trigger
always @*
begin
   nxt_int_trig = 1'b0;
   if (trigger_choice[0] == `IOT_SEL_PIN_TAG)
   begin
      nxt_int_trig = pick_bit(pin_vec, {1'b0, trigger_choice[3:1]});
   end
   else if (trigger_choice[1:0] == `IOT_SEL_SHF_TAG)
   begin
      nxt_int_trig = pick_bit(shf_vec, {2'h0, trigger_choice[3:2]});
   end
   else
   begin
      nxt_int_trig = pick_bit(tmr_vec, {2'h0, trigger_choice[3:2]});
   end
end

// External triggers index directly by the full choice value
assign nxt_raw_trig = trigger_origin ? nxt_int_trig
   : pick_bit(ext_vec, trigger_choice);

// Active-low triggers are inverted before the timer sees them
assign nxt_trig = nxt_raw_trig ^ trigger_polarity;

// ==========================================
// Timer pin

// Input side: selected pin, polarity folded in
assign nxt_pin_in = pick_bit(pin_vec, {1'b0, pin_choice}) ^ pin_polarity;

// Output side: timer output at the pin's active level
assign drive_level = timer_out ^ pin_polarity;

// Only the chosen pin is touched; all others stay released.
// Open-drain/enable mode puts the level on the enable, which
// also serves as the enable for a partner driving the data.
always @*
begin
   nxt_pin_out = {NPINS{1'b0}};
   nxt_pin_oe = {NPINS{1'b0}};
   case (pin_drive_config)
      `IOT_PCFG_OFF:
      begin
         nxt_pin_oe[pin_choice] = 1'b0;
      end
      `IOT_PCFG_OD_OE:
      begin
         nxt_pin_oe[pin_choice] = drive_level;
      end
      `IOT_PCFG_BIDIR:
      begin
         nxt_pin_out[pin_choice] = drive_level;
      end
      `IOT_PCFG_OUT:
      begin
         nxt_pin_out[pin_choice] = drive_level;
         nxt_pin_oe[pin_choice] = 1'b1;
      end
      default:
      begin
         nxt_pin_oe = {NPINS{1'b0}};
      end
   endcase
end

// Registered outputs keep the pads glitch-free when the
// configuration is rewritten
always @(posedge pclk or negedge presetn)
begin
   if (!presetn)
   begin
      trig_ff <= 1'b0;
      pin_in_ff <= 1'b0;
      pin_out_ff <= {NPINS{1'b0}};
      pin_oe_ff <= {NPINS{1'b0}};
   end
   else
   begin
      trig_ff <= nxt_trig;
      pin_in_ff <= nxt_pin_in;
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff <= nxt_pin_oe;
   end
end

// ==========================================
// Outputs
assign prdata = prdata_ff;
assign pready = pready_ff;
assign pslverr = pslverr_ff;
assign pin_out = pin_out_ff;
assign pin_oe = pin_oe_ff;
assign trigger_active = trig_ff;
assign timer_pin_in = pin_in_ff;

endmodule

//--- bench/io_far_side.sv
`timescale 1ns/10ps

// ==========================================
// Far side: pins, sibling timers, shifters and external triggers
module io_far_side (
   input wire pclk,
   input wire [7:0] pin_set,
   input wire [3:0] ext_set,
   output reg [7:0] pin_in = 8'h00,
   output reg [3:0] ext_trig = 4'h0,
   output reg [3:0] shifter_flag = 4'h0,
   output reg [3:0] timer_trig = 4'h0,
   output reg timer_out = 1'b0
);
   // Pins hold the bench's level; same-clock sources move every cycle,
   // so a stale mux select cannot match by luck
   always @(posedge pclk)
   begin
      pin_in <= pin_set;
      ext_trig <= ext_set;
      shifter_flag <= 4'($urandom);
      timer_trig <= 4'($urandom);
      timer_out <= 1'($urandom);
   end
endmodule

//--- bench/io_tpc_asserts.sv
`timescale 1ns/10ps
`include "io_timer_consts.vh"

// ==========================================
// Port checker for the trigger and pin block
module io_tpc_asserts #(
   parameter NPINS = 8,
   parameter NSHIFT = 4,
   parameter NTIMERS = 4,
   parameter NEXT = 4
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`IOT_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [NSHIFT-1:0] shifter_flag,
   input wire [NTIMERS-1:0] timer_trig,
   input wire timer_out,
   input wire [NPINS-1:0] pin_out,
   input wire [NPINS-1:0] pin_oe,
   input wire trigger_active
);
   reg [31:0] ctl_ff;
   wire [1:0] cfg = ctl_ff[17:16];
   wire [2:0] ps = ctl_ff[10:8];
   wire lvl = timer_out ^ ctl_ff[7];

   // Shadow of the control word, taken only at a completed write
   always @(posedge pclk or negedge presetn)
      if (!presetn)
         ctl_ff <= 32'h00000000;
      else if (psel && penable && pready && pwrite && paddr[11:2] == 10'h000)
         ctl_ff <= pwdata & `IOT_CTRL_WMASK;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait;
      !pready ##1 pready;
   endsequence

   a_one_wait: assert property ($rose(penable) && psel |-> s_wait)
      else $error("pready not in second access cycle");
   a_rsvd_zero: assert property (pready && !pwrite |-> (prdata & 32'h003CF800) == 0)
      else $error("reserved bits read nonzero");
   a_ctrl_back: assert property (pready && !pwrite && paddr[11:2] == 0 |-> prdata == ctl_ff)
      else $error("control readback wrong");
   a_drive_off: assert property (cfg == 2'h0 |=> pin_oe == 0 && pin_out == 0)
      else $error("pin driven while disabled");
   a_drive_out: assert property (cfg == 2'h3 |=> pin_oe == (NPINS'(1) << $past(ps)))
      else $error("output enable wrong");
   a_pin_data: assert property (cfg[1] |=> pin_out == (NPINS'($past(lvl)) << $past(ps)))
      else $error("pin data wrong");
   a_od_enable: assert property (cfg == 2'h1 |=>
      pin_out == 0 && pin_oe == (NPINS'($past(lvl)) << $past(ps)))
      else $error("open drain enable wrong");
   a_shift_trig: assert property (ctl_ff[22] && ctl_ff[25:24] == 2'h1 |=>
      trigger_active == $past(shifter_flag[ctl_ff[27:26]] ^ ctl_ff[23]))
      else $error("shifter trigger wrong");
   a_timer_trig: assert property (ctl_ff[22] && ctl_ff[25:24] == 2'h3 |=>
      trigger_active == $past(timer_trig[ctl_ff[27:26]] ^ ctl_ff[23]))
      else $error("timer trigger wrong");
endmodule

bind io_timer_trigger_pin_config io_tpc_asserts #(.NPINS(NPINS), .NSHIFT(NSHIFT),
   .NTIMERS(NTIMERS), .NEXT(NEXT)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .shifter_flag, .timer_trig, .timer_out,
   .pin_out, .pin_oe, .trigger_active);

//--- bench/io_timer_trigger_pin_config_test.sv
`timescale 1ns/10ps

// ==========================================
// Self-checking bench for the trigger and pin block
module io_timer_trigger_pin_config_test;
   reg pclk, presetn, psel, penable, pwrite, er, tv;
   reg [11:0] paddr;
   reg [31:0] pwdata, rd, c;
   reg [7:0] pin_set;
   reg [3:0] ext_set, sf, tt;
   wire [31:0] prdata;
   wire pready, pslverr, timer_out, trigger_active, timer_pin_in;
   wire [7:0] pin_in, pin_out, pin_oe;
   wire [3:0] ext_trig, shifter_flag, timer_trig;
   integer n_mismatch = 0;
   integer n_checks = 0;
   integer i;

   io_timer_trigger_pin_config dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .pin_in, .ext_trig, .shifter_flag,
      .timer_trig, .timer_out, .pin_out, .pin_oe, .trigger_active, .timer_pin_in);
   io_far_side far (.pclk, .pin_set, .ext_set, .pin_in, .ext_trig, .shifter_flag,
      .timer_trig, .timer_out);

   // ==========================================
   // Clock and helpers
   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task chk(input logic ok, input string m);
      n_checks++;
      if (!ok)
      begin
         n_mismatch++;
         $display("BAD %0t %s", $time, m);
      end
   endtask

   // One APB transfer; the master never assumes the slave's latency
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // pready is looked at from the first access edge on
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Reference trigger: mux, then polarity
   function logic exp_trig(input logic [31:0] k, input logic [7:0] p,
      input logic [3:0] e, input logic [3:0] s, input logic [3:0] t);
      logic [3:0] n;
      n = k[27:24];
      if (!k[22]) exp_trig = e[n[1:0]];
      else if (!n[0]) exp_trig = p[n[3:1]];
      else if (n[1]) exp_trig = t[n[3:2]];
      else exp_trig = s[n[3:2]];
      exp_trig = exp_trig ^ k[23];
   endfunction

   task print_verdict;
      if (n_mismatch == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pin_set, ext_set} = 0;
      i = $urandom(28);
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd === 32'h00000000, "reset value");
      apb(1'b1, 12'h000, 32'hFFFFFFFF);
      apb(1'b0, 12'h000, 32'h0);
      chk(rd === 32'h0FC30780, "write mask");
      apb(1'b0, 12'h008, 32'h0);
      chk(er === 1'b1, "unmapped");
      // Every origin and drive code, random choices and polarities
      for (i = 0; i < 48; i++)
      begin
         c = $urandom & 32'h0F830780;
         c[22] = i[2];
         c[17:16] = i[1:0];
         if (!c[22]) c[27:26] = 2'h0;
         apb(1'b1, 12'h000, c | ($urandom & 32'h003CF800));
         pin_set <= 8'($urandom);
         ext_set <= 4'($urandom);
         apb(1'b0, 12'h000, 32'h0);
         chk(rd === c, "readback");
         chk(er === 1'b0, "error on mapped read");
         repeat (6) @(posedge pclk);
         @(negedge pclk);
         sf = shifter_flag;
         tt = timer_trig;
         tv = timer_out ^ c[7];
         @(negedge pclk);
         chk(trigger_active === exp_trig(c, pin_set, ext_set, sf, tt), "trigger");
         chk(timer_pin_in === (pin_set[c[10:8]] ^ c[7]), "pin input");
         chk(pin_out === (c[17] ? {7'h00, tv} << c[10:8] : 8'h00), "pin data");
         chk(pin_oe === (c[16] ? {7'h00, c[17] | tv} << c[10:8] : 8'h00), "enable");
      end
      print_verdict;
   end

   // Hang guard, well past the expected run length
   initial
   begin
      #100000;
      n_mismatch++;
      print_verdict;
   end
endmodule
